// file: src/alu_params.svh
// Register offsets, field positions and reset values of the arithmetic datapath
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH
`define ADR_STATUS_WORD 8'hD0
`define ADR_MAIN_OPERAND 8'hE0
`define ADR_AUX_REGISTER 8'hF0
`define ADR_COMMAND 8'h04
`define ADR_SECOND_OPERAND 8'h08
`define ADR_RESULT_STATUS 8'h0C
`define POS_CARRY 7
`define POS_HALF_CARRY 6
`define POS_USER_ZERO 5
`define POS_BANK_HI 4
`define POS_BANK_LO 3
`define POS_RANGE_ERROR 2
`define POS_USER_ONE 1
`define POS_PARITY 0
`define RESET_BYTE 8'h00
`define BANK_SPAN_BITS 3
`endif

// file: src/alu_pkg.sv
// Operation codes and command layout of the arithmetic datapath
package alu_pkg;
    typedef enum logic [4:0] {
        OP_ADD = 5'h00, OP_ADDC = 5'h01, OP_SUBB = 5'h02, OP_MUL = 5'h03,
        OP_DIV = 5'h04, OP_INC = 5'h05, OP_DEC = 5'h06, OP_DECADJ = 5'h07,
        OP_CMP = 5'h08, OP_AND = 5'h09, OP_OR = 5'h0A, OP_XOR = 5'h0B,
        OP_CPL = 5'h0C, OP_CLR = 5'h0D, OP_RL = 5'h0E, OP_RLC = 5'h0F,
        OP_RR = 5'h10, OP_RRC = 5'h11, OP_SETBIT = 5'h12, OP_CLRBIT = 5'h13,
        OP_CPLBIT = 5'h14, OP_BRCLR = 5'h15, OP_BRSETCLR = 5'h16,
        OP_BITTOC = 5'h17, OP_CTOBIT = 5'h18, OP_SETC = 5'h19,
        OP_CLRC = 5'h1A, OP_CPLC = 5'h1B
    } alu_op_e;

    typedef struct packed {
        logic [2:0] bitSel;
        alu_op_e op;
    } alu_cmd_s;
endpackage : alu_pkg

// file: src/mcu_alu_status_datapath.sv
// Arithmetic, logic and bit datapath with status word, behind a Wishbone slave
//
// Our own choice: the Wishbone interface to the registers.
`include "alu_params.svh"
module mcu_alu_status_datapath
    import alu_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    // Datapath status
    output logic [4:0] bankBase,
    output logic branchTaken,
    output logic parityFlag
);
    logic [7:0] mainOperand;
    logic [7:0] auxReg;
    logic [7:0] secondOperand;
    alu_cmd_s lastCmd;
    logic carryFlag;
    logic halfCarryFlag;
    logic userFlagZero;
    logic [1:0] workBankSelect;
    logic signedRangeErrorFlag;
    logic userFlagOne;

    logic [7:0] next_main;
    logic [7:0] next_aux;
    logic next_carry;
    logic next_half;
    logic next_range;
    logic next_branch;
    logic [8:0] wideSum;
    logic [4:0] nibbleSum;
    logic [15:0] product;
    logic [8:0] adjusted;
    logic [7:0] statusWord;
    logic [31:0] readData;

    // A new request is taken only while no answer is outstanding
    logic take;
    logic wrByte;
    logic exec;
    alu_cmd_s cmdIn;
    assign take = cyc_i && stb_i && !ack_o && ce;
    assign wrByte = take && we_i && sel_i[0];
    assign exec = wrByte && (adr_i == `ADR_COMMAND);
    assign cmdIn = alu_cmd_s'(dat_i[7:0]);

    // Status-word parity is not stored; it is derived from the live operand (parityFlag is a registered copy)
    always_comb begin
        statusWord = {carryFlag, halfCarryFlag, userFlagZero, workBankSelect,
                      signedRangeErrorFlag, userFlagOne, ^mainOperand};
    end

    always_comb begin
        next_main = mainOperand;
        next_aux = auxReg;
        next_carry = carryFlag;
        next_half = halfCarryFlag;
        next_range = signedRangeErrorFlag;
        next_branch = 1'b0;
        wideSum = 9'h000;
        nibbleSum = 5'h00;
        product = 16'h0000;
        adjusted = 9'h000;
        case (cmdIn.op)
            OP_ADD, OP_ADDC: begin
                wideSum = {1'b0, mainOperand} + {1'b0, secondOperand}
                          + {8'h00, (cmdIn.op == OP_ADDC) && carryFlag};
                nibbleSum = {1'b0, mainOperand[3:0]} + {1'b0, secondOperand[3:0]}
                            + {4'h0, (cmdIn.op == OP_ADDC) && carryFlag};
                next_main = wideSum[7:0];
                next_carry = wideSum[8];
                next_half = nibbleSum[4];
                next_range = (mainOperand[7] == secondOperand[7])
                             && (wideSum[7] != mainOperand[7]);
            end
            OP_SUBB: begin
                wideSum = {1'b0, mainOperand} - {1'b0, secondOperand} - {8'h00, carryFlag};
                nibbleSum = {1'b0, mainOperand[3:0]} - {1'b0, secondOperand[3:0]}
                            - {4'h0, carryFlag};
                next_main = wideSum[7:0];
                next_carry = wideSum[8];
                next_half = nibbleSum[4];
                next_range = (mainOperand[7] != secondOperand[7])
                             && (wideSum[7] != mainOperand[7]);
            end
            OP_MUL: begin
                product = mainOperand * auxReg;
                next_main = product[7:0];
                next_aux = product[15:8];
                next_carry = 1'b0;
                next_range = |product[15:8];
            end
            OP_DIV: begin
                next_carry = 1'b0;
                // Divide by zero leaves both registers untouched and flags the error
                if (auxReg == 8'h00) begin
                    next_range = 1'b1;
                end else begin
                    next_main = mainOperand / auxReg;
                    next_aux = mainOperand % auxReg;
                    next_range = 1'b0;
                end
            end
            OP_INC: next_main = mainOperand + 8'h01;
            OP_DEC: next_main = mainOperand - 8'h01;
            OP_DECADJ: begin
                adjusted = {1'b0, mainOperand};
                if (mainOperand[3:0] > 4'h9 || halfCarryFlag) begin
                    adjusted = adjusted + 9'h006;
                end
                if (adjusted[7:4] > 4'h9 || carryFlag || adjusted[8]) begin
                    adjusted = adjusted + 9'h060;
                end
                next_main = adjusted[7:0];
                next_carry = carryFlag || adjusted[8];
            end
            OP_CMP: begin
                next_carry = mainOperand < secondOperand;
                next_branch = mainOperand != secondOperand;
            end
            OP_AND: next_main = mainOperand & secondOperand;
            OP_OR: next_main = mainOperand | secondOperand;
            OP_XOR: next_main = mainOperand ^ secondOperand;
            OP_CPL: next_main = ~mainOperand;
            OP_CLR: next_main = 8'h00;
            OP_RL: next_main = {mainOperand[6:0], mainOperand[7]};
            OP_RR: next_main = {mainOperand[0], mainOperand[7:1]};
            OP_RLC: begin
                next_main = {mainOperand[6:0], carryFlag};
                next_carry = mainOperand[7];
            end
            OP_RRC: begin
                next_main = {carryFlag, mainOperand[7:1]};
                next_carry = mainOperand[0];
            end
            OP_SETBIT: next_main[cmdIn.bitSel] = 1'b1;
            OP_CLRBIT: next_main[cmdIn.bitSel] = 1'b0;
            OP_CPLBIT: next_main[cmdIn.bitSel] = ~mainOperand[cmdIn.bitSel];
            OP_BRCLR: next_branch = !mainOperand[cmdIn.bitSel];
            OP_BRSETCLR: begin
                next_branch = mainOperand[cmdIn.bitSel];
                next_main[cmdIn.bitSel] = 1'b0;
            end
            OP_BITTOC: next_carry = mainOperand[cmdIn.bitSel];
            OP_CTOBIT: next_main[cmdIn.bitSel] = carryFlag;
            OP_SETC: next_carry = 1'b1;
            OP_CLRC: next_carry = 1'b0;
            OP_CPLC: next_carry = !carryFlag;
            default: next_branch = 1'b0;
        endcase
    end

    always_comb begin
        case (adr_i)
            `ADR_STATUS_WORD: readData = {24'h000000, statusWord};
            `ADR_MAIN_OPERAND: readData = {24'h000000, mainOperand};
            `ADR_AUX_REGISTER: readData = {24'h000000, auxReg};
            `ADR_COMMAND: readData = {24'h000000, lastCmd};
            `ADR_SECOND_OPERAND: readData = {24'h000000, secondOperand};
            `ADR_RESULT_STATUS: readData = {31'h00000000, branchTaken};
            default: readData = 32'h00000000;
        endcase
    end

    // Bus answer: one cycle after the request, unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else if (ce) begin
            ack_o <= take;
            if (take && !we_i) begin
                dat_o <= readData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mainOperand <= `RESET_BYTE;
        end else if (ce) begin
            if (wrByte && adr_i == `ADR_MAIN_OPERAND) begin
                mainOperand <= dat_i[7:0];
            end else if (exec) begin
                mainOperand <= next_main;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            auxReg <= `RESET_BYTE;
        end else if (ce) begin
            if (wrByte && adr_i == `ADR_AUX_REGISTER) begin
                auxReg <= dat_i[7:0];
            end else if (exec) begin
                auxReg <= next_aux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            secondOperand <= `RESET_BYTE;
            lastCmd <= alu_cmd_s'(`RESET_BYTE);
            branchTaken <= 1'b0;
        end else if (ce) begin
            if (wrByte && adr_i == `ADR_SECOND_OPERAND) begin
                secondOperand <= dat_i[7:0];
            end
            if (exec) begin
                lastCmd <= cmdIn;
                branchTaken <= next_branch;
            end
        end
    end

    // A bus write and an operation never share a cycle, so no flag race exists
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            carryFlag <= 1'b0;
            halfCarryFlag <= 1'b0;
            userFlagZero <= 1'b0;
            workBankSelect <= 2'b00;
            signedRangeErrorFlag <= 1'b0;
            userFlagOne <= 1'b0;
        end else if (ce) begin
            if (wrByte && adr_i == `ADR_STATUS_WORD) begin
                carryFlag <= dat_i[`POS_CARRY];
                halfCarryFlag <= dat_i[`POS_HALF_CARRY];
                userFlagZero <= dat_i[`POS_USER_ZERO];
                workBankSelect <= dat_i[`POS_BANK_HI:`POS_BANK_LO];
                signedRangeErrorFlag <= dat_i[`POS_RANGE_ERROR];
                userFlagOne <= dat_i[`POS_USER_ONE];
            end else if (exec) begin
                carryFlag <= next_carry;
                halfCarryFlag <= next_half;
                signedRangeErrorFlag <= next_range;
            end
        end
    end

    // Registered copies lag the live state by one enabled cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bankBase <= 5'h00;
            parityFlag <= 1'b0;
        end else if (ce) begin
            bankBase <= {workBankSelect, {`BANK_SPAN_BITS{1'b0}}};
            parityFlag <= ^mainOperand;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic [8:0] plainSum;
    logic [15:0] fullProduct;
    assign plainSum = {1'b0, mainOperand} + {1'b0, secondOperand};
    assign fullProduct = mainOperand * auxReg;

    sequence runOp(alu_op_e code);
        exec && cmdIn.op == code;
    endsequence

    chk_answer_once: assert property (take |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse after request");
    chk_add_carry: assert property (runOp(OP_ADD) |=>
        carryFlag == $past(plainSum[8]) && mainOperand == $past(plainSum[7:0]))
        else $error("add result or carry wrong");
    chk_mul_split: assert property (runOp(OP_MUL) |=>
        {auxReg, mainOperand} == $past(fullProduct) && !carryFlag)
        else $error("multiply result not split over aux and main");
    // The sequence is chained with ##0 because it may not be a boolean operand
    chk_div_zero: assert property (runOp(OP_DIV) ##0 auxReg == 8'h00 |=>
        signedRangeErrorFlag && mainOperand == $past(mainOperand) && auxReg == 8'h00)
        else $error("divide by zero not flagged");
    chk_xor_logic: assert property (runOp(OP_XOR) |=>
        mainOperand == ($past(mainOperand) ^ $past(secondOperand)))
        else $error("exclusive-or wrong");
    // Bit index comes from the command seen at the executing edge
    chk_bit_branch: assert property (runOp(OP_BRSETCLR) |=>
        !mainOperand[lastCmd.bitSel] && branchTaken == $past(mainOperand[cmdIn.bitSel]))
        else $error("branch-and-clear wrong");
    chk_bank_base: assert property (ce ##1 ce |->
        bankBase[4:3] == $past(workBankSelect) && bankBase[2:0] == 3'b000)
        else $error("bank base mismatch");
    chk_parity_follow: assert property (ce |=> parityFlag == ^$past(mainOperand))
        else $error("parity does not follow operand");
    chk_user_flags: assert property (wrByte && adr_i == `ADR_STATUS_WORD |=>
        userFlagZero == $past(dat_i[5]) && userFlagOne == $past(dat_i[1]))
        else $error("user flags not stored");
    // Reset acts on every edge whatever the enable, since each flop tests rst_b before ce
    chk_status_reset: assert property (disable iff (1'b0) !rst_b && ce |=>
        statusWord == 8'h00)
        else $error("status word not cleared by reset");
endmodule : mcu_alu_status_datapath

// file: test/tb_top.sv
// Self-checking bench for the arithmetic and status datapath
`include "alu_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] p0;
        logic [7:0] em;
        logic [7:0] ea;
        logic [7:0] ep;
        logic br;
    } row_s;
    // Status expectation leaves parity clear; it is added from the expected main result
    row_s rows [29] = '{
        '{8'h00, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h01, 8'h44, 1'b0},
        '{8'h01, 8'hFF, 8'h00, 8'h80, 8'h00, 8'h00, 8'hC0, 1'b0},
        '{8'h02, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h01, 8'hC0, 1'b0},
        '{8'h03, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h04, 1'b0},
        '{8'h04, 8'h64, 8'h07, 8'h00, 8'h0E, 8'h02, 8'h00, 1'b0},
        '{8'h05, 8'hFF, 8'h00, 8'h22, 8'h00, 8'h00, 8'h22, 1'b0},
        '{8'h06, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 1'b0},
        '{8'h07, 8'h0A, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 1'b0},
        '{8'h08, 8'h05, 8'h09, 8'h00, 8'h05, 8'h09, 8'h80, 1'b1},
        '{8'h09, 8'hF0, 8'h3C, 8'h00, 8'h30, 8'h3C, 8'h00, 1'b0},
        '{8'h0A, 8'hF0, 8'h0F, 8'h00, 8'hFF, 8'h0F, 8'h00, 1'b0},
        '{8'h0B, 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'h0F, 8'h00, 1'b0},
        '{8'h0C, 8'h5A, 8'h00, 8'h00, 8'hA5, 8'h00, 8'h00, 1'b0},
        '{8'h0D, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0},
        '{8'h0E, 8'h81, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 1'b0},
        '{8'h0F, 8'h01, 8'h00, 8'h80, 8'h03, 8'h00, 8'h00, 1'b0},
        '{8'h10, 8'h81, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 1'b0},
        '{8'h11, 8'h81, 8'h00, 8'h00, 8'h40, 8'h00, 8'h80, 1'b0},
        '{8'hF2, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 1'b0},
        '{8'h13, 8'hFF, 8'h00, 8'h00, 8'hFE, 8'h00, 8'h00, 1'b0},
        '{8'h74, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 1'b0},
        '{8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1},
        '{8'hB6, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1},
        '{8'h37, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h80, 1'b0},
        '{8'h18, 8'hFF, 8'h00, 8'h00, 8'hFE, 8'h00, 8'h00, 1'b0},
        '{8'h19, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 1'b0},
        '{8'h1A, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0},
        '{8'h1B, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0},
        '{8'h1F, 8'h55, 8'h00, 8'h22, 8'h55, 8'h00, 8'h22, 1'b0}
    };
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic ack;
    logic [31:0] datOut;
    logic [4:0] bankBase;
    logic branchTaken;
    logic parityFlag;
    logic [7:0] q;
    int n_fail = 0;
    int checks_done = 0;

    always #10 clk = ~clk;

    mcu_alu_status_datapath u_dut (
        .clk(clk), .rst_b(rst_b), .ce(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .ack_o(ack), .dat_o(datOut),
        .bankBase(bankBase), .branchTaken(branchTaken), .parityFlag(parityFlag)
    );

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // Request held until ack is sampled high; the bound only guards against a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = datOut[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk1(n < 50, 1'b1);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk8(q, exp);
    endtask : rdchk

    task automatic results;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(`ADR_STATUS_WORD, `RESET_BYTE);
        rdchk(`ADR_MAIN_OPERAND, `RESET_BYTE);
        rdchk(`ADR_AUX_REGISTER, `RESET_BYTE);
        chk1(parityFlag, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(`ADR_STATUS_WORD, rows[i].p0);
            wr(`ADR_MAIN_OPERAND, rows[i].a);
            wr(`ADR_SECOND_OPERAND, rows[i].b);
            wr(`ADR_AUX_REGISTER, rows[i].b);
            wr(`ADR_COMMAND, rows[i].cmd);
            rdchk(`ADR_MAIN_OPERAND, rows[i].em);
            rdchk(`ADR_AUX_REGISTER, rows[i].ea);
            rdchk(`ADR_STATUS_WORD, rows[i].ep | {7'h0, ^rows[i].em});
            rdchk(`ADR_RESULT_STATUS, {7'h0, rows[i].br});
            chk1(branchTaken, rows[i].br);
            chk1(parityFlag, ^rows[i].em);
        end
        $display("test operation table done");
        wr(`ADR_MAIN_OPERAND, 8'h07);
        for (int b = 0; b < 4; b++) begin
            wr(`ADR_STATUS_WORD, 8'(b << `POS_BANK_LO));
            rdchk(`ADR_STATUS_WORD, 8'(b << `POS_BANK_LO) | 8'h01);
            chk8({3'h0, bankBase}, 8'(b * 8));
        end
        $display("test bank select done");
        // Second reset in mid-run with non-zero registers and bank 3 selected
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(`ADR_STATUS_WORD, `RESET_BYTE);
        rdchk(`ADR_MAIN_OPERAND, `RESET_BYTE);
        chk8({3'h0, bankBase}, 8'h00);
        $display("test mid-run reset done");
        wr(`ADR_STATUS_WORD, 8'h01);
        rdchk(`ADR_STATUS_WORD, 8'h00);
        wr(`ADR_MAIN_OPERAND, 8'h40);
        wr(`ADR_AUX_REGISTER, 8'h00);
        wr(`ADR_COMMAND, 8'h04);
        rdchk(`ADR_MAIN_OPERAND, 8'h40);
        rdchk(`ADR_STATUS_WORD, 8'h05);
        wr(8'h30, 8'hAA);
        rdchk(8'h30, 8'h00);
        $display("test awkward cases done");
        // A request raised while the enable is low must wait unanswered and unapplied
        @(posedge clk);
        ce <= 1'b0;
        fork
            wr(`ADR_MAIN_OPERAND, 8'h3C);
            begin
                repeat (4) @(posedge clk);
                chk1(ack, 1'b0);
                chk1(parityFlag, 1'b1);
                ce <= 1'b1;
            end
        join
        rdchk(`ADR_MAIN_OPERAND, 8'h3C);
        chk1(parityFlag, 1'b0);
        $display("test clock enable done");
        results();
    end
endmodule : tb_top
